// ===== verilog/tsb_defs.vh
// constants shared by the two-line serial bus channel files
`ifndef TSB_DEFS_VH
`define TSB_DEFS_VH

// ==========================================================
// register byte offsets
`define TSB_OFF_CTRL 8'h00
`define TSB_OFF_STAT 8'h04
`define TSB_OFF_SHIFT 8'h08
`define TSB_OFF_SADDR 8'h0C
`define TSB_OFF_ACKTO 8'h10

// ==========================================================
// control register fields
`define TSB_CTRL_EN 0
`define TSB_CTRL_WAKE 1
`define TSB_CTRL_ACKE 2
`define TSB_CTRL_BSYE 3
`define TSB_CTRL_RLSG 4
`define TSB_CTRL_CMDG 5

// ==========================================================
// status register fields
`define TSB_STAT_DONE 0
`define TSB_STAT_RELD 1
`define TSB_STAT_CMDD 2
`define TSB_STAT_MATCH 3
`define TSB_STAT_SEL 4
`define TSB_STAT_ACKD 5
`define TSB_STAT_ACKF 6
`define TSB_STAT_BUSY 7
`define TSB_STAT_ACT 8
`define TSB_STAT_CLS 9

// ==========================================================
// item classes
`define TSB_CLS_DATA 2'h0
`define TSB_CLS_CMD 2'h1
`define TSB_CLS_ADDR 2'h2

// ==========================================================
// reset values and counts
`define TSB_SADDR_RST 8'h00
`define TSB_ACKTO_RST 16'h0400
`define TSB_BITS 4'h8

// ==========================================================
// bus responses
`define TSB_RESP_OKAY 2'h0
`define TSB_RESP_SLVERR 2'h2

`endif

// ===== verilog/tsb_sync.v
// two-flop synchroniser for pin inputs, one chain per bit
`timescale 1ns/100ps
module tsb_sync #(
    parameter W = 2
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);

// ==========================================================
// per-bit chains
genvar i;
generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
        reg meta_r;
        reg sync_r;
        // first stage feeds only the second
        always @(posedge aclk) begin
            if (!aresetn) begin
                meta_r <= 1'b1;
                sync_r <= 1'b1;
            end else if (ce) begin
                meta_r <= d_in[i];
                sync_r <= meta_r;
            end
        end
        assign q_out[i] = sync_r;
    end
endgenerate

endmodule // tsb_sync

// ===== verilog/tsb_axil.v
// axi4-lite slave front end with address decode
`timescale 1ns/100ps
`include "tsb_defs.vh"
module tsb_axil (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire wr_en,
    output wire [7:0] wr_addr,
    output wire [31:0] wr_data,
    output wire [3:0] wr_strb,
    output wire [7:0] rd_addr,
    input wire [31:0] rd_data
);

reg aw_full_r;
reg w_full_r;
reg [7:0] awaddr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg bvalid_r;
reg [1:0] bresp_r;
reg rvalid_r;
reg [1:0] rresp_r;
reg [31:0] rdata_r;
wire wr_fire;
wire wr_ok;
wire rd_ok;

// ==========================================================
// decode of mapped words
function addr_ok;
    input [7:0] a;
    begin
        addr_ok = (a == `TSB_OFF_CTRL) || (a == `TSB_OFF_STAT) ||
            (a == `TSB_OFF_SHIFT) || (a == `TSB_OFF_SADDR) ||
            (a == `TSB_OFF_ACKTO);
    end
endfunction

// handshakes and strobes
assign s_axi_awready = !aw_full_r;
assign s_axi_wready = !w_full_r;
assign s_axi_arready = !rvalid_r;
assign s_axi_bvalid = bvalid_r;
assign s_axi_bresp = bresp_r;
assign s_axi_rvalid = rvalid_r;
assign s_axi_rresp = rresp_r;
assign s_axi_rdata = rdata_r;
assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
assign wr_ok = addr_ok(awaddr_r);
assign rd_ok = addr_ok(s_axi_araddr);
assign wr_en = wr_fire && wr_ok;
assign wr_addr = awaddr_r;
assign wr_data = wdata_r;
assign wr_strb = wstrb_r;
assign rd_addr = s_axi_araddr;

// ==========================================================
// write path: address and data in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        awaddr_r <= 8'h00;
        wdata_r <= 32'h00000000;
        wstrb_r <= 4'h0;
        bvalid_r <= 1'b0;
        bresp_r <= `TSB_RESP_OKAY;
    end else if (ce) begin
        if (s_axi_awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? `TSB_RESP_OKAY : `TSB_RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
end

// ==========================================================
// read path: data latched when the address is taken
always @(posedge aclk) begin
    if (!aresetn) begin
        rvalid_r <= 1'b0;
        rresp_r <= `TSB_RESP_OKAY;
        rdata_r <= 32'h00000000;
    end else if (ce) begin
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_ok ? `TSB_RESP_OKAY : `TSB_RESP_SLVERR;
            rdata_r <= rd_ok ? rd_data : 32'h00000000;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
end

endmodule // tsb_axil

// ===== verilog/tsb_top.v
// two-line serial bus channel: framing, shifter, ack, busy
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "tsb_defs.vh"
module tsb_top (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire serial_clock_line,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe,
    output wire channel_interrupt
);

wire wr_en;
wire [7:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire [7:0] rd_addr;
reg [31:0] rd_data;
wire [1:0] pin_s;
wire sck_s;
wire sda_s;
reg sck_p_r;
reg sda_p_r;
reg channel_enable_r;
reg wakeup_select_r;
reg ack_enable_r;
reg busy_enable_r;
reg [7:0] slave_addr_r;
reg [15:0] ack_to_r;
reg [7:0] shift_register_r;
reg [3:0] bit_cnt_r;
reg active_r;
reg serial_output_latch_r;
reg transfer_done_flag_r;
reg rls_seen_r;
reg free_pend_r;
reg cmd_seen_r;
reg match_r;
reg selected_r;
reg [1:0] cls_r;
reg ack_pend_r;
reg ack_drv_r;
reg busy_r;
reg ack_wait_r;
reg [15:0] ack_cnt_r;
reg ack_det_r;
reg ack_fail_r;
reg chan_int_r;
reg sda_oe_r;
wire sck_fall;
wire sck_rise;
wire rls_det;
wire cmd_det;
wire done_evt;
wire is_addr;
wire addr_hit;
wire [1:0] item_cls;
wire [31:0] wmask;
wire ctrl_wr;
wire stat_wr;
wire shift_wr;
wire en_nxt;
wire rls_trig;
wire cmd_trig;
wire start;

// ==========================================================
// register bus front end
tsb_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
);

// ==========================================================
// pin synchronisers and edge detection
tsb_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d_in({serial_clock_line, sda_i}),
    .q_out(pin_s)
);

assign sck_s = pin_s[1];
assign sda_s = pin_s[0];

// previous synchronised levels
always @(posedge aclk) begin
    if (!aresetn) begin
        sck_p_r <= 1'b1;
        sda_p_r <= 1'b1;
    end else if (ce) begin
        sck_p_r <= sck_s;
        sda_p_r <= sda_s;
    end
end

// clock edges and framing conditions with clock held high
assign sck_fall = sck_p_r && !sck_s;
assign sck_rise = !sck_p_r && sck_s;
assign rls_det = channel_enable_r && sck_p_r && sck_s &&
    !sda_p_r && sda_s;
assign cmd_det = channel_enable_r && sck_p_r && sck_s &&
    sda_p_r && !sda_s;

// ==========================================================
// register write decode
assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
    {8{wr_strb[1]}}, {8{wr_strb[0]}}};
assign ctrl_wr = wr_en && (wr_addr == `TSB_OFF_CTRL) && wr_strb[0];
assign stat_wr = wr_en && (wr_addr == `TSB_OFF_STAT) && wr_strb[0];
assign shift_wr = wr_en && (wr_addr == `TSB_OFF_SHIFT) && wr_strb[0];
assign en_nxt = ctrl_wr ? wr_data[`TSB_CTRL_EN] : channel_enable_r;
// triggers act only if the write leaves the channel enabled and are never stored
assign rls_trig = ctrl_wr && en_nxt && wr_data[`TSB_CTRL_RLSG];
assign cmd_trig = ctrl_wr && en_nxt && wr_data[`TSB_CTRL_CMDG];
// a transfer starts only if already enabled and idle
assign start = shift_wr && channel_enable_r && !active_r;

// ==========================================================
// item end and classification
assign done_evt = active_r && sck_rise &&
    (bit_cnt_r == `TSB_BITS - 4'h1);
assign is_addr = rls_seen_r && cmd_seen_r;
assign item_cls = is_addr ? `TSB_CLS_ADDR :
    (cmd_seen_r ? `TSB_CLS_CMD : `TSB_CLS_DATA);
assign addr_hit = ({shift_register_r[6:0], sda_s} ==
    slave_addr_r);

// ==========================================================
// control registers
always @(posedge aclk) begin
    if (!aresetn) begin
        channel_enable_r <= 1'b0;
        wakeup_select_r <= 1'b0;
        ack_enable_r <= 1'b0;
        busy_enable_r <= 1'b0;
        slave_addr_r <= `TSB_SADDR_RST;
        ack_to_r <= `TSB_ACKTO_RST;
    end else if (ce && wr_en) begin
        if (ctrl_wr) begin
            channel_enable_r <= wr_data[`TSB_CTRL_EN];
            wakeup_select_r <= wr_data[`TSB_CTRL_WAKE];
            ack_enable_r <= wr_data[`TSB_CTRL_ACKE];
            busy_enable_r <= wr_data[`TSB_CTRL_BSYE];
        end
        if (wr_addr == `TSB_OFF_SADDR && wr_strb[0])
            slave_addr_r <= wr_data[7:0];
        if (wr_addr == `TSB_OFF_ACKTO)
            ack_to_r <= (ack_to_r & ~wmask[15:0]) |
                (wr_data[15:0] & wmask[15:0]);
    end
end

// ==========================================================
// shifter, output latch and framing state
always @(posedge aclk) begin
    if (!aresetn) begin
        shift_register_r <= 8'h00;
        bit_cnt_r <= 4'h0;
        active_r <= 1'b0;
        serial_output_latch_r <= 1'b1;
        free_pend_r <= 1'b0;
        rls_seen_r <= 1'b0;
        cmd_seen_r <= 1'b0;
        match_r <= 1'b0;
        selected_r <= 1'b0;
        cls_r <= `TSB_CLS_DATA;
        transfer_done_flag_r <= 1'b0;
        chan_int_r <= 1'b0;
    end else if (ce) begin
        chan_int_r <= 1'b0;
        // done flag: set wins over write-one-to-clear
        if (done_evt)
            transfer_done_flag_r <= 1'b1;
        else if (stat_wr && wr_data[`TSB_STAT_DONE])
            transfer_done_flag_r <= 1'b0;
        if (!channel_enable_r) begin
            active_r <= 1'b0;
            free_pend_r <= 1'b0;
            rls_seen_r <= 1'b0;
            cmd_seen_r <= 1'b0;
            match_r <= 1'b0;
            selected_r <= 1'b0;
            if (rls_trig)
                serial_output_latch_r <= 1'b1;
            else if (cmd_trig)
                serial_output_latch_r <= 1'b0;
        end else if (start) begin
            shift_register_r <= wr_data[7:0];
            bit_cnt_r <= 4'h0;
            active_r <= 1'b1;
            free_pend_r <= 1'b0;
            rls_seen_r <= 1'b0;
            cmd_seen_r <= 1'b0;
        end else begin
            // line freed at the fall after an item, never with clock high
            if (free_pend_r && sck_fall) begin
                free_pend_r <= 1'b0;
                serial_output_latch_r <= 1'b1;
            end
            if (rls_trig)
                serial_output_latch_r <= 1'b1;
            else if (cmd_trig)
                serial_output_latch_r <= 1'b0;
            // release clears command and selection
            if (rls_det) begin
                rls_seen_r <= 1'b1;
                cmd_seen_r <= 1'b0;
                selected_r <= 1'b0;
            end else if (cmd_det) begin
                cmd_seen_r <= 1'b1;
            end
            if (active_r && sck_fall)
                serial_output_latch_r <= shift_register_r[7];
            if (active_r && sck_rise) begin
                shift_register_r <= {shift_register_r[6:0], sda_s};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (done_evt) begin
                active_r <= 1'b0;
                free_pend_r <= 1'b1;
                cls_r <= item_cls;
                if (is_addr) begin
                    match_r <= addr_hit;
                    selected_r <= addr_hit;
                    if (wakeup_select_r && !addr_hit)
                        rls_seen_r <= 1'b0;
                end
                chan_int_r <= !wakeup_select_r ||
                    (is_addr && addr_hit);
            end
        end
    end
end

// ==========================================================
// acknowledge, busy and ack watch
always @(posedge aclk) begin
    if (!aresetn) begin
        ack_pend_r <= 1'b0;
        ack_drv_r <= 1'b0;
        busy_r <= 1'b0;
        ack_wait_r <= 1'b0;
        ack_cnt_r <= 16'h0000;
        ack_det_r <= 1'b0;
        ack_fail_r <= 1'b0;
    end else if (ce) begin
        if (stat_wr && wr_data[`TSB_STAT_ACKF])
            ack_fail_r <= 1'b0;
        if (!channel_enable_r) begin
            ack_pend_r <= 1'b0;
            ack_drv_r <= 1'b0;
            busy_r <= 1'b0;
            ack_wait_r <= 1'b0;
        end else if (done_evt) begin
            ack_det_r <= 1'b0;
            // receiver answers, transmitter watches
            ack_pend_r <= ack_enable_r;
            ack_wait_r <= !ack_enable_r;
            ack_cnt_r <= ack_to_r;
        end else begin
            if (sck_fall) begin
                if (ack_pend_r) begin
                    ack_pend_r <= 1'b0;
                    ack_drv_r <= 1'b1;
                end else if (ack_drv_r) begin
                    ack_drv_r <= 1'b0;
                    busy_r <= busy_enable_r;
                end else if (busy_r && !busy_enable_r &&
                        !wakeup_select_r) begin
                    busy_r <= 1'b0;
                end
            end
            if (ack_wait_r) begin
                if (sck_rise && !sda_s) begin
                    ack_wait_r <= 1'b0;
                    ack_det_r <= 1'b1;
                end else if (ack_cnt_r == 16'h0000) begin
                    ack_wait_r <= 1'b0;
                    ack_fail_r <= 1'b1;
                end else begin
                    ack_cnt_r <= ack_cnt_r - 16'h0001;
                end
            end
        end
    end
end

// ==========================================================
// open-drain data line drive, registered
always @(posedge aclk) begin
    if (!aresetn)
        sda_oe_r <= 1'b0;
    else if (ce)
        sda_oe_r <= channel_enable_r &&
            (!serial_output_latch_r || ack_drv_r || busy_r);
end

assign sda_o = 1'b0; // only ever pulls low
assign sda_oe = sda_oe_r;
assign channel_interrupt = chan_int_r;

// ==========================================================
// register read mux
always @* begin
    rd_data = 32'h00000000;
    case (rd_addr)
    `TSB_OFF_CTRL: begin
        rd_data[`TSB_CTRL_EN] = channel_enable_r;
        rd_data[`TSB_CTRL_WAKE] = wakeup_select_r;
        rd_data[`TSB_CTRL_ACKE] = ack_enable_r;
        rd_data[`TSB_CTRL_BSYE] = busy_enable_r;
    end
    `TSB_OFF_STAT: begin
        rd_data[`TSB_STAT_DONE] = transfer_done_flag_r;
        rd_data[`TSB_STAT_RELD] = rls_seen_r;
        rd_data[`TSB_STAT_CMDD] = cmd_seen_r;
        rd_data[`TSB_STAT_MATCH] = match_r;
        rd_data[`TSB_STAT_SEL] = selected_r;
        rd_data[`TSB_STAT_ACKD] = ack_det_r;
        rd_data[`TSB_STAT_ACKF] = ack_fail_r;
        rd_data[`TSB_STAT_BUSY] = busy_r;
        rd_data[`TSB_STAT_ACT] = active_r;
        rd_data[`TSB_STAT_CLS+1:`TSB_STAT_CLS] = cls_r;
    end
    `TSB_OFF_SHIFT: rd_data[7:0] = shift_register_r;
    `TSB_OFF_SADDR: rd_data[7:0] = slave_addr_r;
    `TSB_OFF_ACKTO: rd_data[15:0] = ack_to_r;
    default: rd_data = 32'h00000000;
    endcase
end

endmodule // tsb_top

// ===== verif/tsb_chk.sv
// assertion checker for the two-line serial bus channel ports
`timescale 1ns/100ps
module tsb_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire serial_clock_line,
    input wire sda_o,
    input wire sda_oe,
    input wire channel_interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========
    // cycles since the last serial clock fall and rise, saturating
    logic scl_d_r;
    logic [3:0] fall_age_r;
    logic [3:0] rise_age_r;
    always @(posedge aclk) begin
        scl_d_r <= serial_clock_line;
        if (!aresetn || (scl_d_r && !serial_clock_line)) begin
            fall_age_r <= aresetn ? 4'h0 : 4'hF;
        end else if (fall_age_r != 4'hF) begin
            fall_age_r <= fall_age_r + 4'h1;
        end
        if (!aresetn || (!scl_d_r && serial_clock_line)) begin
            rise_age_r <= aresetn ? 4'h0 : 4'hF;
        end else if (rise_age_r != 4'hF) begin
            rise_age_r <= rise_age_r + 4'h1;
        end
    end
    // ==========
    // properties
    chk_od_low: assert property (!sda_o)
        else $error("data line driven high");
    chk_irq_pulse: assert property (
        channel_interrupt |=> !channel_interrupt)
        else $error("interrupt longer than one cycle");
    chk_irq_rise: assert property (
        $rose(channel_interrupt) |-> rise_age_r <= 4'h6)
        else $error("interrupt not tied to a clock rise");
    chk_oe_fall: assert property (
        $changed(sda_oe) |-> fall_age_r <= 4'h7 || s_axi_bvalid
        || $past(s_axi_bvalid))
        else $error("data line moved away from clock fall");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    chk_aw_refuse: assert property ($rose(s_axi_bvalid)
        |-> !$past(s_axi_awready))
        else $error("address not held until its response");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during read data");
endmodule // tsb_chk

bind tsb_top tsb_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .serial_clock_line(serial_clock_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .channel_interrupt(channel_interrupt));

// ===== verif/tsb_bus_master.sv
// behavioural bus master on the serial clock and data lines
`timescale 1ns/100ps
module tsb_bus_master (
    output logic scl,
    output logic mst_oe,
    input wire line
);
    // clock stands high and data released between frames
    initial begin
        scl = 1'b1;
        mst_oe = 1'b0;
    end
    // one 160 ns clock: data moves while low, sampled mid-high;
    // edges kept 5 ns off the aclk edges so pin sampling has no race
    task automatic clk1(input logic drv, output logic v);
        #5 scl = 1'b0;
        #40 mst_oe = drv;
        #40 scl = 1'b1;
        #40 v = line;
        #35;
    endtask
    // framing conditions made with the clock held high
    task automatic frame(input logic rls, input logic cmd);
        if (rls) begin
            mst_oe = 1'b1;
            #80 mst_oe = 1'b0; // low to high, clock high
            #80;
        end
        if (cmd) begin
            mst_oe = 1'b1; // high to low, clock high
            #80;
        end
    endtask
    // eight bits, msb first
    task automatic xfer(input logic [7:0] b, output logic [7:0] got);
        for (int i = 7; i >= 0; i--) clk1(!b[i], got[i]);
    endtask
endmodule // tsb_bus_master

// ===== verif/tsb_tb.sv
// self-checking testbench for the two-line serial bus channel
`timescale 1ns/100ps
`include "tsb_defs.vh"
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic sda_o, sda_oe, irq, scl, mst_oe, line;
    logic [31:0] irq_cnt = 32'h0;
    int err_total = 0;
    int samples_checked = 0;
    // ==========
    // clock, wired data line with pull-up, interrupt count
    always #10 aclk = ~aclk;
    assign line = !(sda_oe && !sda_o) && !mst_oe;
    always @(posedge aclk) if (irq) irq_cnt <= irq_cnt + 32'h1;
    tsb_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_clock_line(scl), .sda_i(line), .sda_o(sda_o),
        .sda_oe(sda_oe), .channel_interrupt(irq));
    tsb_bus_master bm (.scl(scl), .mst_oe(mst_oe), .line(line));
    // ==========
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d & m, e);
    endtask
    // shift armed, framing, eight bits from the master
    task automatic item(input logic rls, input logic cmd,
        input logic [7:0] b);
        logic [7:0] g;
        wr(`TSB_OFF_SHIFT, 32'hFF);
        bm.frame(rls, cmd);
        bm.xfer(b, g);
        #200;
    endtask
    // one clock of acknowledge, then the line free again
    task automatic ack;
        logic v;
        bm.clk1(1'b0, v);
        chk(32'(v), 32'h0);
        bm.clk1(1'b0, v);
        chk(32'(v), 32'h1);
    endtask
    task automatic complete_run;
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========
    // watchdog
    initial begin
        #400000;
        err_total++;
        complete_run;
    end
    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] g;
        logic v;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(`TSB_OFF_SADDR, 32'hFF, {24'h0, `TSB_SADDR_RST});
        rdchk(`TSB_OFF_ACKTO, 32'hFFFF, {16'h0, `TSB_ACKTO_RST});
        rdchk(`TSB_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(8'h14, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, `TSB_RESP_SLVERR});
        wr(8'h14, 32'h0);
        chk({30'h0, bresp}, {30'h0, `TSB_RESP_SLVERR});
        wr(`TSB_OFF_SHIFT, 32'hFF);
        wr(`TSB_OFF_CTRL, 32'h01);
        rdchk(`TSB_OFF_STAT, 32'h100, 32'h0);
        wr(`TSB_OFF_CTRL, 32'h21);
        repeat (2) @(posedge aclk);
        chk(32'(sda_oe), 32'h1);
        rdchk(`TSB_OFF_CTRL, 32'h30, 32'h0);
        wr(`TSB_OFF_CTRL, 32'h11);
        repeat (2) @(posedge aclk);
        chk(32'(sda_oe), 32'h0);
        // matching address with wake-up on
        wr(`TSB_OFF_SADDR, 32'h5A);
        chk({30'h0, bresp}, {30'h0, `TSB_RESP_OKAY});
        wr(`TSB_OFF_CTRL, 32'h07);
        item(1'b1, 1'b1, 8'h5A);
        chk(irq_cnt, 32'h1);
        rdchk(`TSB_OFF_STAT, 32'h619, 32'h419);
        ack;
        // command then data, wake-up off, selection kept
        wr(`TSB_OFF_CTRL, 32'h05);
        item(1'b0, 1'b1, 8'hC3);
        chk(irq_cnt, 32'h2);
        rdchk(`TSB_OFF_STAT, 32'h610, 32'h210);
        ack;
        item(1'b0, 1'b0, 8'h96);
        rdchk(`TSB_OFF_STAT, 32'h610, 32'h010);
        ack;
        // busy after ack, removal waits for a clock fall
        wr(`TSB_OFF_CTRL, 32'h0D);
        item(1'b0, 1'b0, 8'h3C);
        bm.clk1(1'b0, v);
        chk(32'(v), 32'h0);
        bm.clk1(1'b0, v);
        chk(32'(v), 32'h0);
        rdchk(`TSB_OFF_STAT, 32'h80, 32'h80);
        wr(`TSB_OFF_CTRL, 32'h05);
        chk(32'(line), 32'h0);
        bm.clk1(1'b0, v);
        chk(32'(v), 32'h1);
        // foreign address with wake-up on
        wr(`TSB_OFF_CTRL, 32'h07);
        item(1'b1, 1'b1, 8'h33);
        chk(irq_cnt, 32'h4);
        rdchk(`TSB_OFF_STAT, 32'h18, 32'h0);
        bm.clk1(1'b0, v);
        bm.clk1(1'b0, v);
        // device transmits, nobody acknowledges
        wr(`TSB_OFF_ACKTO, 32'h20);
        wr(`TSB_OFF_CTRL, 32'h01);
        wr(`TSB_OFF_SHIFT, 32'hA5);
        bm.xfer(8'hFF, g);
        chk({24'h0, g}, 32'hA5);
        #1500;
        rdchk(`TSB_OFF_STAT, 32'h41, 32'h41);
        // device transmits, master acknowledges
        wr(`TSB_OFF_SHIFT, 32'h5A);
        bm.xfer(8'hFF, g);
        chk({24'h0, g}, 32'h5A);
        bm.clk1(1'b1, v);
        rdchk(`TSB_OFF_STAT, 32'h20, 32'h20);
        complete_run;
    end
endmodule // testbench
